/* vector_add_accelerator.sv */
// Vector add engine: machine-state registers, dispatch, sixteen adder units and the running sum
//
// How it works
// [RULE1] Each dispatched add reads paired operands from two arrays, adds them and stores each result.
// [RULE2] Sixteen identical adder units each take every sixteenth element and run concurrently.
// [RULE3] In direct mode each unit talks only to its own controller port; a crossbar may route instead.
// [RULE4] Operand reads go through an in-order read cache; crossbar and async interface are optional.
// [RULE5] Register index 0 holds the first source array base address.
// [RULE6] Register index 1 holds the second source array base address.
// [RULE7] Register index 2 holds the destination array base address.
// [RULE8] Register index 3 holds the number of element additions.
// [RULE9] Engine n exposes its accumulated result sum at register index 30 plus n.
// [RULE10] Without the crossbar, any base not aligned to the first controller raises exception bit 2.
// [RULE11] Result overflow and sum overflow both raise exception bit 1.
// [RULE12] Operands and results are signed 64-bit integers and each result is the operand sum.
// [RULE13] Element j of each array sits at its base plus eight times j, for j below the count.
// [RULE14] Broadcast runs every masked-in engine; directed runs only the named engine if it is masked in.
// [RULE15] The running sum is cleared at the start of each dispatched add.
`timescale 1ns/10ps
module vector_add_accelerator (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // Dispatch
  input  wire logic               disp_start,
  input  wire logic               disp_broadcast,
  input  wire logic [1:0]         disp_engine,
  input  wire logic [3:0]         engine_enable_mask,
  input  wire logic [1:0]         engine_id,
  input  wire logic               crossbar_en,
  output logic                    busy,
  output logic                    op_done,
  output logic [15:0]             exception_bits,
  // Machine-state registers
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_idx,
  input  wire logic [63:0]        reg_wdata,
  output logic                    reg_rvalid,
  output logic [63:0]             reg_rdata,
  // Memory read ports, one per unit
  output logic [15:0]             rd_req,
  output logic [15:0][63:0]       rd_addr,
  input  wire logic [15:0]        rd_ready,
  input  wire logic [15:0]        rsp_valid,
  input  wire logic [15:0][63:0]  rsp_data,
  // Memory write ports, one per unit
  output logic [15:0]             wr_req,
  output logic [15:0][63:0]       wr_addr,
  output logic [15:0][63:0]       wr_data,
  input  wire logic [15:0]        wr_ready
);
  vadd_pkg::main_state_e state_r;
  logic [63:0]           source_a_base_r;
  logic [63:0]           source_b_base_r;
  logic [63:0]           result_base_r;
  logic [63:0]           element_count_r;
  logic [63:0]           engine_sums_r;
  logic [63:0]           sum_nxt;
  logic                  sum_ovf;
  logic                  res_ovf_any;
  logic                  go_r;
  logic                  participate;
  logic                  accept;
  logic                  unaligned;
  logic                  unaligned_base_error;
  logic [15:0]           unit_idle;
  logic [15:0]           res_valid;
  logic [15:0]           res_ovf;
  logic [15:0][63:0]     res_data;
  logic [7:0]            own_sum_idx;

  // [RULE14] engine selection from mask and broadcast
  assign participate = engine_enable_mask[engine_id] && (disp_broadcast || (disp_engine == engine_id));
  assign accept      = disp_start && participate && (state_r == vadd_pkg::M_IDLE);
  assign own_sum_idx = vadd_pkg::IDX_SUM_BASE + {6'h00, engine_id};

  // [RULE10] alignment to the first controller
  assign unaligned = (source_a_base_r[vadd_pkg::ALIGN_BITS-1:0] != '0) ||
                     (source_b_base_r[vadd_pkg::ALIGN_BITS-1:0] != '0) ||
                     (result_base_r[vadd_pkg::ALIGN_BITS-1:0] != '0);
  assign unaligned_base_error = accept && !crossbar_en && unaligned;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= vadd_pkg::M_IDLE;
      go_r    <= 1'b0;
    end else begin
      go_r <= 1'b0;
      case (state_r)
        vadd_pkg::M_IDLE: begin
          if (unaligned_base_error) begin
            state_r <= vadd_pkg::M_DONE;
          end else if (accept) begin
            state_r <= vadd_pkg::M_RUN;
            go_r    <= 1'b1;
          end
        end
        // Units leave idle the cycle after go, so skip the check in that cycle
        vadd_pkg::M_RUN:  if (!go_r && (&unit_idle) && (res_valid == '0)) state_r <= vadd_pkg::M_DONE;
        vadd_pkg::M_DONE: state_r <= vadd_pkg::M_IDLE;
        default:          state_r <= vadd_pkg::M_IDLE;
      endcase
    end
  end

  assign busy    = (state_r != vadd_pkg::M_IDLE);
  assign op_done = (state_r == vadd_pkg::M_DONE);

  // Registers are locked while busy so the units see stable bases
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      source_a_base_r <= vadd_pkg::REG_RESET;
      source_b_base_r <= vadd_pkg::REG_RESET;
      result_base_r   <= vadd_pkg::REG_RESET;
      element_count_r <= vadd_pkg::REG_RESET;
    end else if (reg_wr && !busy) begin
      case (reg_idx)
        // [RULE5] first source base
        vadd_pkg::IDX_SOURCE_A: source_a_base_r <= reg_wdata;
        // [RULE6] second source base
        vadd_pkg::IDX_SOURCE_B: source_b_base_r <= reg_wdata;
        // [RULE7] destination base
        vadd_pkg::IDX_RESULT:   result_base_r   <= reg_wdata;
        // [RULE8] element count
        vadd_pkg::IDX_COUNT:    element_count_r <= reg_wdata;
        default:                ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
      reg_rdata  <= vadd_pkg::REG_RESET;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_idx == vadd_pkg::IDX_SOURCE_A) reg_rdata <= source_a_base_r;
        else if (reg_idx == vadd_pkg::IDX_SOURCE_B) reg_rdata <= source_b_base_r;
        else if (reg_idx == vadd_pkg::IDX_RESULT) reg_rdata <= result_base_r;
        else if (reg_idx == vadd_pkg::IDX_COUNT) reg_rdata <= element_count_r;
        // [RULE9] own sum at 30 plus engine number
        else if (reg_idx == own_sum_idx) reg_rdata <= engine_sums_r;
        else reg_rdata <= vadd_pkg::REG_RESET;
      end
    end
  end

  // All sixteen results of one cycle fold into the sum in a single chain
  always_comb begin
    sum_nxt     = engine_sums_r;
    sum_ovf     = 1'b0;
    res_ovf_any = 1'b0;
    for (int i = 0; i < vadd_pkg::NUM_UNITS; i++) begin
      if (res_valid[i]) begin
        if (vadd_pkg::add_ovf(sum_nxt, res_data[i], sum_nxt + res_data[i])) sum_ovf = 1'b1;
        sum_nxt     = sum_nxt + res_data[i];
        res_ovf_any = res_ovf_any | res_ovf[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      engine_sums_r <= vadd_pkg::REG_RESET;
    end else if (accept) begin
      // [RULE15] clear sum at dispatch
      engine_sums_r <= vadd_pkg::REG_RESET;
    end else begin
      engine_sums_r <= sum_nxt;
    end
  end

  // Exceptions are cleared only at dispatch, when no unit can report an event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exception_bits <= '0;
    end else if (accept) begin
      exception_bits <= '0;
      if (unaligned_base_error) exception_bits[vadd_pkg::EXC_UNALIGNED] <= 1'b1;
    end else if (res_ovf_any || sum_ovf) begin
      // [RULE11] result and sum overflow on bit 1
      exception_bits[vadd_pkg::EXC_OVERFLOW] <= 1'b1;
    end
  end

  // [RULE3] direct mode: unit i owns port i
  // [RULE4] in-order answers from the read cache
  for (genvar g = 0; g < vadd_pkg::NUM_UNITS; g++) begin : g_unit
    vadd_unit #(
      .UNIT (64'(g))
    ) u_unit (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .go        (go_r),
      .src_a     (source_a_base_r),
      .src_b     (source_b_base_r),
      .dst       (result_base_r),
      .count     (element_count_r),
      .idle      (unit_idle[g]),
      .res_valid (res_valid[g]),
      .res_data  (res_data[g]),
      .res_ovf   (res_ovf[g]),
      .rd_req    (rd_req[g]),
      .rd_addr   (rd_addr[g]),
      .rd_ready  (rd_ready[g]),
      .rsp_valid (rsp_valid[g]),
      .rsp_data  (rsp_data[g]),
      .wr_req    (wr_req[g]),
      .wr_addr   (wr_addr[g]),
      .wr_data   (wr_data[g]),
      .wr_ready  (wr_ready[g])
    );
  end

  sequence s_dispatch_ok;
    accept && !unaligned_base_error;
  endsequence

  sequence s_first_fetch;
    rd_req[0] && (rd_addr[0] == source_a_base_r);
  endsequence

  a_unaligned_abort: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    unaligned_base_error |=> op_done && exception_bits[vadd_pkg::EXC_UNALIGNED] && !go_r)
    else $error("unaligned base did not abort with exception");

  a_sum_cleared: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
    accept |=> (engine_sums_r == vadd_pkg::REG_RESET))
    else $error("sum not cleared at dispatch");

  a_count_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    (reg_wr && !busy && reg_idx == vadd_pkg::IDX_COUNT) |=> (element_count_r == $past(reg_wdata)))
    else $error("count register not written");

  a_base_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    (reg_wr && !busy && reg_idx == vadd_pkg::IDX_SOURCE_A) |=> (source_a_base_r == $past(reg_wdata)))
    else $error("first source base not written");

  a_sum_readback: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (reg_rd && reg_idx == own_sum_idx) |=> reg_rvalid && (reg_rdata == $past(engine_sums_r)))
    else $error("own sum not returned");

  a_not_selected: assert property (@(posedge mclk) disable iff (!rst_n) // RULE14
    (disp_start && !participate && !busy) |=> !busy)
    else $error("engine ran without being selected");

  a_first_fetch: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
    (s_dispatch_ok ##1 (element_count_r != '0)) |-> ##2 s_first_fetch)
    else $error("first read not at first source base");

  a_all_units: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    (go_r && element_count_r >= 64'(vadd_pkg::NUM_UNITS)) |-> ##2 (&rd_req))
    else $error("not all sixteen units fetching");

  a_overflow_flag: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
    (|(res_valid & res_ovf)) && !accept |=> exception_bits[vadd_pkg::EXC_OVERFLOW])
    else $error("result overflow not flagged");

  a_empty_done: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (s_dispatch_ok ##1 (element_count_r == '0)) |-> ##[1:4] op_done)
    else $error("empty add did not finish");
endmodule

/* vadd_pkg.sv */
// Shared constants, states and arithmetic helpers for the vector add engine
package vadd_pkg;
  localparam int          NUM_UNITS       = 16;
  localparam int          NUM_ENGINES     = 4;
  localparam int          DATA_W          = 64;
  localparam int          IDX_W           = 8;
  localparam int          EXC_W           = 16;
  // Machine-state register indices
  localparam logic [7:0]  IDX_SOURCE_A    = 8'h00;
  localparam logic [7:0]  IDX_SOURCE_B    = 8'h01;
  localparam logic [7:0]  IDX_RESULT      = 8'h02;
  localparam logic [7:0]  IDX_COUNT       = 8'h03;
  localparam logic [7:0]  IDX_SUM_BASE    = 8'h1E;
  // Exception bit positions
  localparam int          EXC_OVERFLOW    = 1;
  localparam int          EXC_UNALIGNED   = 2;
  // Element stride in bytes, as a shift
  localparam int          ELEM_SHIFT      = 3;
  // Low address bits that must be zero for a base to sit on the first controller
  localparam int          ALIGN_BITS      = 9;
  localparam logic [63:0] REG_RESET       = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {U_IDLE, U_CHECK, U_READ_A, U_WAIT_A, U_READ_B, U_WAIT_B, U_WRITE} unit_state_e;
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_DONE} main_state_e;

  // Signed overflow of s = a + b
  function automatic logic add_ovf(input logic [63:0] a, input logic [63:0] b, input logic [63:0] s);
    add_ovf = (a[63] == b[63]) && (s[63] != a[63]);
  endfunction

  // Byte address of element j of an array
  function automatic logic [63:0] elem_addr(input logic [63:0] base, input logic [63:0] j);
    elem_addr = base + {j[63-ELEM_SHIFT:0], {ELEM_SHIFT{1'b0}}};
  endfunction
endpackage

/* vadd_unit.sv */
// One adder unit: walks its share of the elements and adds pairs from memory
`timescale 1ns/10ps
module vadd_unit #(
  parameter logic [63:0] UNIT = 64'h0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        go,
  input  wire logic [63:0] src_a,
  input  wire logic [63:0] src_b,
  input  wire logic [63:0] dst,
  input  wire logic [63:0] count,
  output logic             idle,
  output logic             res_valid,
  output logic [63:0]      res_data,
  output logic             res_ovf,
  // Memory read port, in-order answers
  output logic             rd_req,
  output logic [63:0]      rd_addr,
  input  wire logic        rd_ready,
  input  wire logic        rsp_valid,
  input  wire logic [63:0] rsp_data,
  // Memory write port
  output logic             wr_req,
  output logic [63:0]      wr_addr,
  output logic [63:0]      wr_data,
  input  wire logic        wr_ready
);
  localparam logic [63:0] STEP = 64'(vadd_pkg::NUM_UNITS);

  vadd_pkg::unit_state_e state_r;
  logic [63:0]           j_r;
  logic [63:0]           op_a_r;
  logic [63:0]           sum_nxt;

  // [RULE12] signed 64-bit element sum
  assign sum_nxt = op_a_r + rsp_data;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= vadd_pkg::U_IDLE;
    end else begin
      case (state_r)
        vadd_pkg::U_IDLE:   if (go) state_r <= vadd_pkg::U_CHECK;
        vadd_pkg::U_CHECK:  state_r <= (j_r < count) ? vadd_pkg::U_READ_A : vadd_pkg::U_IDLE;
        vadd_pkg::U_READ_A: if (rd_ready) state_r <= vadd_pkg::U_WAIT_A;
        vadd_pkg::U_WAIT_A: if (rsp_valid) state_r <= vadd_pkg::U_READ_B;
        vadd_pkg::U_READ_B: if (rd_ready) state_r <= vadd_pkg::U_WAIT_B;
        vadd_pkg::U_WAIT_B: if (rsp_valid) state_r <= vadd_pkg::U_WRITE;
        vadd_pkg::U_WRITE:  if (wr_ready) state_r <= vadd_pkg::U_CHECK;
        default:            state_r <= vadd_pkg::U_IDLE;
      endcase
    end
  end

  // [RULE2] interleaved share per unit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      j_r <= vadd_pkg::REG_RESET;
    end else if (state_r == vadd_pkg::U_IDLE && go) begin
      j_r <= UNIT;
    end else if (state_r == vadd_pkg::U_WRITE && wr_ready) begin
      j_r <= j_r + STEP;
    end
  end

  // [RULE1] fetch pair, add, store
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_a_r   <= vadd_pkg::REG_RESET;
      wr_data  <= vadd_pkg::REG_RESET;
      res_ovf  <= 1'b0;
    end else if (state_r == vadd_pkg::U_WAIT_A && rsp_valid) begin
      op_a_r <= rsp_data;
    end else if (state_r == vadd_pkg::U_WAIT_B && rsp_valid) begin
      wr_data <= sum_nxt;
      res_ovf <= vadd_pkg::add_ovf(op_a_r, rsp_data, sum_nxt);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_data  <= vadd_pkg::REG_RESET;
    end else begin
      res_valid <= (state_r == vadd_pkg::U_WRITE) && wr_ready;
      res_data  <= wr_data;
    end
  end

  // [RULE13] base plus eight times j
  assign rd_addr = (state_r == vadd_pkg::U_READ_B) ? vadd_pkg::elem_addr(src_b, j_r) : vadd_pkg::elem_addr(src_a, j_r);
  assign wr_addr = vadd_pkg::elem_addr(dst, j_r);
  assign rd_req  = (state_r == vadd_pkg::U_READ_A) || (state_r == vadd_pkg::U_READ_B);
  assign wr_req  = (state_r == vadd_pkg::U_WRITE);
  assign idle    = (state_r == vadd_pkg::U_IDLE);
endmodule

/* vadd_mem_model.sv */
// Memory controller model: one in-order read port and one write port per adder unit
`timescale 1ns/10ps
module vadd_mem_model (
  // Clock, reset and pacing
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              slow,
  // Per-unit read ports
  input  wire logic [15:0]       rd_req,
  input  wire logic [15:0][63:0] rd_addr,
  output logic      [15:0]       rd_ready,
  output logic      [15:0]       rsp_valid,
  output logic      [15:0][63:0] rsp_data,
  // Per-unit write ports
  input  wire logic [15:0]       wr_req,
  input  wire logic [15:0][63:0] wr_addr,
  input  wire logic [15:0][63:0] wr_data,
  output logic      [15:0]       wr_ready
);
  logic [63:0] mem [logic [63:0]];
  int          wport [logic [63:0]];
  logic [15:0] pend;
  logic [63:0] paddr [16];
  logic [1:0]  wait_r [16];
  logic        tick_r;

  // Unwritten words read as their own low address bits
  function automatic logic [63:0] word(input logic [63:0] a);
    word = mem.exists(a) ? mem[a] : {48'h0, a[15:0]};
  endfunction

  // port i serves unit i only
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rd_ready[i] = rd_req[i] && !pend[i] && (!slow || tick_r);
      wr_ready[i] = wr_req[i] && (!slow || tick_r);
    end
  end

  // reads answered in order, data line scrambled between answers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 16'h0;
      rsp_valid <= 16'h0;
      rsp_data <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= !tick_r;
      for (int i = 0; i < 16; i++) begin
        rsp_valid[i] <= 1'b0;
        rsp_data[i] <= ~rsp_data[i];
        if (rd_req[i] && rd_ready[i]) begin
          pend[i] <= 1'b1;
          paddr[i] <= rd_addr[i];
          wait_r[i] <= slow ? 2'h2 : 2'h0;
        end else if (pend[i] && wait_r[i] != 2'h0) begin
          wait_r[i] <= wait_r[i] - 2'h1;
        end else if (pend[i]) begin
          pend[i] <= 1'b0;
          rsp_valid[i] <= 1'b1;
          rsp_data[i] <= word(paddr[i]);
        end
        if (wr_req[i] && wr_ready[i]) begin
          mem[wr_addr[i]] = wr_data[i];
          wport[wr_addr[i]] = i;
        end
      end
    end
  end
endmodule

/* vector_add_accelerator_tb.sv */
// Self-checking bench for the vector add engine
`timescale 1ns/10ps
module vector_add_accelerator_tb;
  typedef struct {logic [63:0] cnt, a, b, d; logic xbar, slw, unal;} row_s;
  logic              mclk = 1'b0, rst_n = 1'b0, disp_start = 1'b0, disp_broadcast = 1'b0;
  logic              crossbar_en = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic [1:0]        disp_engine = 2'h0;
  logic [3:0]        engine_enable_mask = 4'h5;
  logic [7:0]        reg_idx = 8'h00;
  logic [63:0]       reg_wdata = 64'h0, reg_rdata, s;
  logic              busy, op_done, reg_rvalid;
  logic [15:0]       exception_bits, rd_req, rd_ready, rsp_valid, wr_req, wr_ready;
  logic [15:0][63:0] rd_addr, rsp_data, wr_addr, wr_data;
  int                err_total = 0, n_compared = 0, cyc;
  row_s rows [7] = '{'{64'd3, 64'h1000, 64'h2000, 64'h10000, 0, 0, 0},
                     '{64'd0, 64'h1000, 64'h2000, 64'h20000, 0, 0, 0},
                     '{64'd17, 64'h1200, 64'h2400, 64'h30000, 0, 1, 0},
                     '{64'd33, 64'h1000, 64'h2000, 64'h40000, 0, 0, 0},
                     '{64'd5, 64'h1008, 64'h2000, 64'h50000, 0, 0, 1},
                     '{64'd20, 64'h1008, 64'h2010, 64'h60008, 1, 1, 0},
                     '{64'd4, 64'h1000, 64'h2000, 64'h70100, 0, 0, 1}};

  always #2 mclk = ~mclk;

  vector_add_accelerator vector_add_accelerator_inst (.mclk(mclk), .rst_n(rst_n), .disp_start(disp_start),
    .disp_broadcast(disp_broadcast), .disp_engine(disp_engine), .engine_enable_mask(engine_enable_mask),
    .engine_id(2'h2), .crossbar_en(crossbar_en), .busy(busy), .op_done(op_done),
    .exception_bits(exception_bits), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));

  vadd_mem_model vadd_mem_model_inst (.mclk(mclk), .rst_n(rst_n), .slow(slow), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready));

  function automatic logic [63:0] dflt(input logic [63:0] a);
    dflt = {48'h0, a[15:0]};
  endfunction

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] idx, input logic [63:0] val);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_idx <= idx;
    reg_wdata <= val;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] idx, input logic [63:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_idx <= idx;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(64'(reg_rvalid), 64'h1);
    check(reg_rdata, exp);
  endtask

  task automatic set_regs(input logic [63:0] a, b, d, n);
    reg_write(8'h00, a);
    reg_write(8'h01, b);
    reg_write(8'h02, d);
    reg_write(8'h03, n);
  endtask

  task automatic start_op(input logic bc, input logic [1:0] eng);
    @(posedge mclk);
    disp_start <= 1'b1;
    disp_broadcast <= bc;
    disp_engine <= eng;
    @(posedge mclk);
    disp_start <= 1'b0;
    #1;
  endtask

  task automatic wait_done;
    cyc = 0;
    while (op_done !== 1'b1) begin
      @(posedge mclk);
      #1;
      cyc++;
      if (cyc > 5000) begin
        err_total++;
        stop_test();
      end
    end
  endtask

  task automatic run_row(input row_s r);
    logic [63:0] v, e;
    s = 64'h0;
    slow <= r.slw;
    crossbar_en <= r.xbar;
    set_regs(r.a, r.b, r.d, r.cnt);
    start_op(1'b1, 2'h0);
    check(64'(busy), 64'h1);
    wait_done();
    check(64'(exception_bits), r.unal ? 64'h4 : 64'h0);
    if (r.cnt == 64'd0) check(64'(cyc), 64'd3);
    for (int j = 0; j < int'(r.cnt) && !r.unal; j++) begin
      e = r.d + 64'(8 * j);
      v = dflt(r.a + 64'(8 * j)) + dflt(r.b + 64'(8 * j));
      s += v;
      check(vadd_mem_model_inst.mem[e], v);
      check(64'(vadd_mem_model_inst.wport[e]), 64'(j % 16));
    end
    check(64'(vadd_mem_model_inst.mem.exists(r.d + (r.unal ? 64'h0 : 8 * r.cnt))), 64'h0);
    if (!r.unal) reg_read(8'h20, s);
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    #1;
    check(64'(busy), 64'h0);
    check(64'(exception_bits), 64'h0);
    rst_n <= 1'b1;
    reg_read(8'h00, 64'h0);
    reg_read(8'h03, 64'h0);
    foreach (rows[k]) run_row(rows[k]);
    // Refused dispatches, then a directed one with a write dropped while busy
    slow <= 1'b0;
    crossbar_en <= 1'b0;
    set_regs(64'h1000, 64'h2000, 64'h80000, 64'd40);
    reg_read(8'h01, 64'h2000);
    reg_read(8'h02, 64'h80000);
    engine_enable_mask <= 4'hB;
    start_op(1'b1, 2'h2);
    check(64'(busy), 64'h0);
    engine_enable_mask <= 4'h4;
    start_op(1'b0, 2'h1);
    check(64'(busy), 64'h0);
    start_op(1'b0, 2'h2);
    check(64'(busy), 64'h1);
    reg_write(8'h03, 64'd5);
    wait_done();
    reg_read(8'h03, 64'd40);
    s = 64'h0;
    for (int j = 0; j < 40; j++) s += dflt(64'h1000 + 64'(8 * j)) + dflt(64'h2000 + 64'(8 * j));
    reg_write(8'h20, 64'h1234);
    reg_read(8'h20, s);
    reg_read(8'h1E, 64'h0);
    reg_read(8'h05, 64'h0);
    // Sum overflow without result overflow, then result overflow
    vadd_mem_model_inst.mem[64'h90000] = 64'h4000_0000_0000_0000;
    vadd_mem_model_inst.mem[64'h90008] = 64'h4000_0000_0000_0000;
    vadd_mem_model_inst.mem[64'hA0000] = 64'h0;
    vadd_mem_model_inst.mem[64'hA0008] = 64'h0;
    set_regs(64'h90000, 64'hA0000, 64'hB0000, 64'd2);
    start_op(1'b1, 2'h0);
    wait_done();
    check(64'(exception_bits), 64'h2);
    vadd_mem_model_inst.mem[64'h90000] = 64'h7FFF_FFFF_FFFF_FFFF;
    vadd_mem_model_inst.mem[64'hA0000] = 64'h1;
    reg_write(8'h03, 64'd1);
    start_op(1'b1, 2'h0);
    wait_done();
    check(64'(exception_bits), 64'h2);
    check(vadd_mem_model_inst.mem[64'hB0000], 64'h8000_0000_0000_0000);
    // Reset in mid-operation
    set_regs(64'h1000, 64'h2000, 64'hC0000, 64'd40);
    start_op(1'b1, 2'h0);
    rst_n <= 1'b0;
    #1;
    check(64'(busy), 64'h0);
    check(64'(rd_req), 64'h0);
    @(posedge mclk);
    rst_n <= 1'b1;
    reg_read(8'h02, 64'h0);
    stop_test();
  end
endmodule
